// ===== hdl/ipb_prio_bank.sv
`timescale 1ns/10ps
// How it works
// R1: A field value of 7 is the highest level and larger codes mean higher priority.
// R2: A field value of 1 is the lowest active level.
// R3: A field value of 0 disables the source so it never raises a request.
// R4: Unimplemented bits always read as zero.
// R5: At reset every implemented field loads 100, level 4.
// R6: Register 0 holds serial 1 receive at 14-12 and sync serial 1 event at 10-8.
// R7: Register 0 holds sync serial 1 fault at 6-4 and timer 3 at 2-0.
// R8: Register 1 has 15-7 unused, converter done at 6-4, serial 1 transmit at 2-0.
// R9: Register 2 holds input change at 14-12 and comparator at 10-8.
// R10: Register 2 holds two-wire 1 master at 6-4 and two-wire 1 slave at 2-0.
// R11: Register 3 holds capture 8 at 14-12 and capture 7 at 10-8.
// R12: Register 3 has 7-3 unused and external interrupt 1 at 2-0.
// R13: Register 4 holds timer 4 at 14-12 and compare 4 at 10-8.
// R14: Register 4 holds compare 3 at 6-4 with its low four bits unused.
// R15: Register 5 holds serial 2 transmit at 14-12 and serial 2 receive at 10-8.
// R16: Register 5 holds external interrupt 2 at 6-4 and timer 5 at 2-0.
// R17: Writes to unused bits are dropped and every field drives its value out continuously.
module ipb_prio_bank (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Priority fields to the arbiter
   output logic      [2:0]  serial1_rx_prio,
   output logic      [2:0]  sync_serial1_event_prio,
   output logic      [2:0]  sync_serial1_fault_prio,
   output logic      [2:0]  timer3_prio,
   output logic      [2:0]  converter_done_prio,
   output logic      [2:0]  serial1_tx_prio,
   output logic      [2:0]  input_change_prio,
   output logic      [2:0]  comparator_prio,
   output logic      [2:0]  twowire1_master_prio,
   output logic      [2:0]  twowire1_slave_prio,
   output logic      [2:0]  capture8_prio,
   output logic      [2:0]  capture7_prio,
   output logic      [2:0]  ext_irq1_prio,
   output logic      [2:0]  timer4_prio,
   output logic      [2:0]  compare4_prio,
   output logic      [2:0]  compare3_prio,
   output logic      [2:0]  serial2_tx_prio,
   output logic      [2:0]  serial2_rx_prio,
   output logic      [2:0]  ext_irq2_prio,
   output logic      [2:0]  timer5_prio,
   // Per-source enable, high when the field is not 0
   output logic      [19:0] srcEnable,
   // Highest level programmed in the bank, 0 when all are off
   output logic      [2:0]  maxLevel
);
   import ipb_pkg::*;

   // ****************************************************
   // Bus decode
   // ****************************************************
   logic        accessPhase;
   logic        wrStrobe;
   logic        hit;
   logic [2:0]  regIdx;
   logic [15:0] wrMask;
   logic [15:0] rdWord;

   logic [15:0] prioSerial1RxSpi1Timer3_ff;
   logic [15:0] prioConverterSerial1Tx_ff;
   logic [15:0] prioChangeCmpTwowire1_ff;
   logic [15:0] prioCapture87Ext1_ff;
   logic [15:0] prioTimer4Compare43_ff;
   logic [15:0] prioSerial2Ext2Timer5_ff;

   // Zero-wait slave: every access completes in its first access cycle
   assign pready      = 1'b1;
   assign accessPhase = psel & penable;

   always_comb begin
      hit    = 1'b1;
      regIdx = 3'h0;
      case (paddr)
         OFF_PRIO_SERIAL1_RX_SPI1_TIMER3: regIdx = 3'h0;
         OFF_PRIO_CONVERTER_SERIAL1_TX:   regIdx = 3'h1;
         OFF_PRIO_CHANGE_CMP_TWOWIRE1:    regIdx = 3'h2;
         OFF_PRIO_CAPTURE87_EXT1:         regIdx = 3'h3;
         OFF_PRIO_TIMER4_COMPARE43:       regIdx = 3'h4;
         OFF_PRIO_SERIAL2_EXT2_TIMER5:    regIdx = 3'h5;
         default: begin
            hit    = 1'b0;
            regIdx = 3'h7;
         end
      endcase
   end

   // Unmapped addresses are flagged so software sees a wild pointer
   assign pslverr  = accessPhase & ~hit;
   assign wrStrobe = accessPhase & pwrite & hit;
   assign wrMask   = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // Masked update: byte enables gate lanes, unused bits never store
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] impl);
      merge = ((pwdata[15:0] & wrMask) | (old & ~wrMask)) & impl; // R17 R4
   endfunction : merge

   // ****************************************************
   // Priority registers
   // ****************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         prioSerial1RxSpi1Timer3_ff <= RST_REG0; // R5
      end else if (wrStrobe && regIdx == 3'h0) begin
         prioSerial1RxSpi1Timer3_ff <= merge(prioSerial1RxSpi1Timer3_ff, MASK_REG0); // R6 R7
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prioConverterSerial1Tx_ff <= RST_REG1; // R5
      end else if (wrStrobe && regIdx == 3'h1) begin
         prioConverterSerial1Tx_ff <= merge(prioConverterSerial1Tx_ff, MASK_REG1); // R8
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prioChangeCmpTwowire1_ff <= RST_REG2; // R5
      end else if (wrStrobe && regIdx == 3'h2) begin
         prioChangeCmpTwowire1_ff <= merge(prioChangeCmpTwowire1_ff, MASK_REG2); // R9 R10
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prioCapture87Ext1_ff <= RST_REG3; // R5
      end else if (wrStrobe && regIdx == 3'h3) begin
         prioCapture87Ext1_ff <= merge(prioCapture87Ext1_ff, MASK_REG3); // R11 R12
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prioTimer4Compare43_ff <= RST_REG4; // R5
      end else if (wrStrobe && regIdx == 3'h4) begin
         prioTimer4Compare43_ff <= merge(prioTimer4Compare43_ff, MASK_REG4); // R13 R14
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prioSerial2Ext2Timer5_ff <= RST_REG5; // R5
      end else if (wrStrobe && regIdx == 3'h5) begin
         prioSerial2Ext2Timer5_ff <= merge(prioSerial2Ext2Timer5_ff, MASK_REG5); // R15 R16
      end
   end

   // ****************************************************
   // Read path
   // ****************************************************
   always_comb begin
      case (regIdx)
         3'h0:    rdWord = prioSerial1RxSpi1Timer3_ff;
         3'h1:    rdWord = prioConverterSerial1Tx_ff;
         3'h2:    rdWord = prioChangeCmpTwowire1_ff;
         3'h3:    rdWord = prioCapture87Ext1_ff;
         3'h4:    rdWord = prioTimer4Compare43_ff;
         3'h5:    rdWord = prioSerial2Ext2Timer5_ff;
         default: rdWord = 16'h0000;
      endcase
   end

   // Upper half-word and unused bits read zero. The word is captured at the setup edge so
   // that it comes from a flop and stands for the whole zero-wait access cycle.
   logic [31:0] prdata_ff;

   always_ff @(posedge clk) begin
      if (reset) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= {16'h0000, rdWord}; // R4
      end else begin
         prdata_ff <= 32'h0000_0000;
      end
   end

   assign prdata = prdata_ff; // R4

   // ****************************************************
   // Field outputs, straight from the flops
   // ****************************************************
   assign serial1_rx_prio         = prioSerial1RxSpi1Timer3_ff[FLD_HI +: PRIO_W]; // R6 R17
   assign sync_serial1_event_prio = prioSerial1RxSpi1Timer3_ff[FLD_MH +: PRIO_W]; // R6
   assign sync_serial1_fault_prio = prioSerial1RxSpi1Timer3_ff[FLD_ML +: PRIO_W]; // R7
   assign timer3_prio             = prioSerial1RxSpi1Timer3_ff[FLD_LO +: PRIO_W]; // R7
   assign converter_done_prio     = prioConverterSerial1Tx_ff[FLD_ML +: PRIO_W];  // R8
   assign serial1_tx_prio         = prioConverterSerial1Tx_ff[FLD_LO +: PRIO_W];  // R8
   assign input_change_prio       = prioChangeCmpTwowire1_ff[FLD_HI +: PRIO_W];   // R9
   assign comparator_prio         = prioChangeCmpTwowire1_ff[FLD_MH +: PRIO_W];   // R9
   assign twowire1_master_prio    = prioChangeCmpTwowire1_ff[FLD_ML +: PRIO_W];   // R10
   assign twowire1_slave_prio     = prioChangeCmpTwowire1_ff[FLD_LO +: PRIO_W];   // R10
   assign capture8_prio           = prioCapture87Ext1_ff[FLD_HI +: PRIO_W];       // R11
   assign capture7_prio           = prioCapture87Ext1_ff[FLD_MH +: PRIO_W];       // R11
   assign ext_irq1_prio           = prioCapture87Ext1_ff[FLD_LO +: PRIO_W];       // R12
   assign timer4_prio             = prioTimer4Compare43_ff[FLD_HI +: PRIO_W];     // R13
   assign compare4_prio           = prioTimer4Compare43_ff[FLD_MH +: PRIO_W];     // R13
   assign compare3_prio           = prioTimer4Compare43_ff[FLD_ML +: PRIO_W];     // R14
   assign serial2_tx_prio         = prioSerial2Ext2Timer5_ff[FLD_HI +: PRIO_W];   // R15
   assign serial2_rx_prio         = prioSerial2Ext2Timer5_ff[FLD_MH +: PRIO_W];   // R15
   assign ext_irq2_prio           = prioSerial2Ext2Timer5_ff[FLD_ML +: PRIO_W];   // R16
   assign timer5_prio             = prioSerial2Ext2Timer5_ff[FLD_LO +: PRIO_W];   // R16

   // ****************************************************
   // Enables and highest programmed level
   // ****************************************************
   logic [2:0]  allPrio [20];
   logic [19:0] nxt_srcEnable;
   logic [2:0]  nxt_maxLevel;
   logic [19:0] srcEnable_ff;
   logic [2:0]  maxLevel_ff;

   assign allPrio = '{serial1_rx_prio, sync_serial1_event_prio, sync_serial1_fault_prio,
                      timer3_prio, converter_done_prio, serial1_tx_prio,
                      input_change_prio, comparator_prio, twowire1_master_prio,
                      twowire1_slave_prio, capture8_prio, capture7_prio, ext_irq1_prio,
                      timer4_prio, compare4_prio, compare3_prio, serial2_tx_prio,
                      serial2_rx_prio, ext_irq2_prio, timer5_prio};

   // Code 0 keeps a source out of arbitration entirely; codes 1..7 rank upward
   always_comb begin
      nxt_srcEnable = 20'h00000;
      nxt_maxLevel  = PRIO_OFF;
      for (int i = 0; i < 20; i++) begin
         nxt_srcEnable[19 - i] = (allPrio[i] != PRIO_OFF); // R3
         if (allPrio[i] > nxt_maxLevel) begin // R1 R2
            nxt_maxLevel = allPrio[i];
         end
      end
   end

   // Registered for the arbiter; limitation: both trail a field write by one clock
   always_ff @(posedge clk) begin
      if (reset) begin
         // Every field resets to a non-zero level, so all sources start enabled
         srcEnable_ff <= 20'hfffff; // R5
         maxLevel_ff  <= PRIO_RESET; // R5
      end else begin
         srcEnable_ff <= nxt_srcEnable; // R3
         maxLevel_ff  <= nxt_maxLevel; // R1 R2
      end
   end

   assign srcEnable = srcEnable_ff;
   assign maxLevel  = maxLevel_ff;

   // ****************************************************
   // Checks
   // ****************************************************
   sequence s_rd_setup;
      psel && !penable && !pwrite;
   endsequence

   sequence s_rd_access;
      psel && penable && !pwrite;
   endsequence

   sequence s_wr_miss;
      psel && penable && pwrite && !hit;
   endsequence

   sequence s_wr_reg0;
      wrStrobe && regIdx == 3'h0 && pstrb[1:0] == 2'h3;
   endsequence

   // Enables and level trail the fields by one clock
   AST_HIGHEST: assert property (@(posedge clk) disable iff (reset) // R1
      (timer3_prio == PRIO_HIGHEST) |=> (maxLevel == PRIO_HIGHEST))
      else $error("level 7 field not seen as highest");

   AST_LOWEST: assert property (@(posedge clk) disable iff (reset) // R2
      (timer3_prio == PRIO_LOWEST) |=> (srcEnable[16] && maxLevel >= PRIO_LOWEST))
      else $error("level 1 field not enabled");

   AST_DISABLED: assert property (@(posedge clk) disable iff (reset) // R3
      (serial1_rx_prio == PRIO_OFF) |=> !srcEnable[19])
      else $error("zero field still enabled");

   AST_ENABLE_OFF: assert property (@(posedge clk) disable iff (reset) // R3
      (timer5_prio == PRIO_OFF) |=> !srcEnable[0])
      else $error("zero timer 5 field still enabled");

   AST_ENABLE_ON: assert property (@(posedge clk) disable iff (reset) // R3
      (compare3_prio != PRIO_OFF) |=> srcEnable[4])
      else $error("nonzero compare 3 field not enabled");

   AST_ZERO_BITS: assert property (@(posedge clk) disable iff (reset) // R4
      (accessPhase && !pwrite) |-> (prdata[31:16] == 16'h0000
         && (regIdx != 3'h1 || prdata[15:7] == 9'h000)
         && (regIdx != 3'h3 || prdata[7:3] == 5'h00)
         && (regIdx != 3'h4 || prdata[3:0] == 4'h0)))
      else $error("unimplemented bits read nonzero");

   AST_READ_DATA: assert property (@(posedge clk) disable iff (reset) // R4
      s_rd_setup ##1 s_rd_access |-> (prdata == {16'h0000, rdWord}))
      else $error("read data not the addressed word");

   AST_MISS_READ: assert property (@(posedge clk) disable iff (reset) // R4
      (psel && penable && !pwrite && !hit) |-> (prdata == 32'h0000_0000 && pslverr))
      else $error("unmapped read not zero with error");

   AST_RESET_VAL: assert property (@(posedge clk) // R5
      reset |=> (prioSerial1RxSpi1Timer3_ff == RST_REG0
         && prioCapture87Ext1_ff == RST_REG3 && compare3_prio == PRIO_RESET))
      else $error("reset value wrong");

   AST_RESET_OUT: assert property (@(posedge clk) // R5
      reset |=> (srcEnable == 20'hfffff && maxLevel == PRIO_RESET))
      else $error("enables or level wrong after reset");

   AST_REG0_WRITE: assert property (@(posedge clk) disable iff (reset) // R6 R7
      s_wr_reg0 ##1 1'b1 |-> (serial1_rx_prio == $past(pwdata[14:12])
         && timer3_prio == $past(pwdata[2:0])))
      else $error("register 0 field placement wrong");

   AST_REG1_HOLD: assert property (@(posedge clk) disable iff (reset) // R8
      1'b1 |-> (prioConverterSerial1Tx_ff[15:7] == 9'h000))
      else $error("register 1 unused bits set");

   AST_REG1_WRITE: assert property (@(posedge clk) disable iff (reset) // R8
      (wrStrobe && regIdx == 3'h1 && pstrb[0]) |=>
         (converter_done_prio == $past(pwdata[6:4])
         && serial1_tx_prio == $past(pwdata[2:0])))
      else $error("register 1 field placement wrong");

   AST_REG2_WRITE: assert property (@(posedge clk) disable iff (reset) // R9 R10
      (wrStrobe && regIdx == 3'h2 && pstrb[1:0] == 2'h3) |=>
         (input_change_prio == $past(pwdata[14:12])
         && comparator_prio == $past(pwdata[10:8])
         && twowire1_master_prio == $past(pwdata[6:4])
         && twowire1_slave_prio == $past(pwdata[2:0])))
      else $error("register 2 field placement wrong");

   AST_REG3_WRITE: assert property (@(posedge clk) disable iff (reset) // R11 R12
      (wrStrobe && regIdx == 3'h3 && pstrb[1:0] == 2'h3) |=>
         (capture8_prio == $past(pwdata[14:12]) && capture7_prio == $past(pwdata[10:8])
         && ext_irq1_prio == $past(pwdata[2:0]) && prioCapture87Ext1_ff[7:3] == 5'h00))
      else $error("register 3 field placement wrong");

   AST_REG4_WRITE: assert property (@(posedge clk) disable iff (reset) // R14 R17
      (wrStrobe && regIdx == 3'h4 && pstrb[0]) |=> (compare3_prio == $past(pwdata[6:4])
         && prioTimer4Compare43_ff[3:0] == 4'h0))
      else $error("register 4 low bits or compare 3 wrong");

   AST_REG5_WRITE: assert property (@(posedge clk) disable iff (reset) // R15 R16
      (wrStrobe && regIdx == 3'h5 && pstrb[1:0] == 2'h3) |=>
         (serial2_rx_prio == $past(pwdata[10:8]) && ext_irq2_prio == $past(pwdata[6:4])))
      else $error("register 5 field placement wrong");

   AST_STABLE: assert property (@(posedge clk) disable iff (reset) // R17
      !wrStrobe |=> $stable(prioSerial2Ext2Timer5_ff))
      else $error("register changed without a write");

   // Unmapped writes and lanes with their strobe low must leave stored bits alone
   AST_MISS_NOWRITE: assert property (@(posedge clk) disable iff (reset) // R17
      s_wr_miss |=> ($stable(prioSerial1RxSpi1Timer3_ff) && $stable(prioConverterSerial1Tx_ff)
         && $stable(prioChangeCmpTwowire1_ff) && $stable(prioCapture87Ext1_ff)
         && $stable(prioTimer4Compare43_ff) && $stable(prioSerial2Ext2Timer5_ff)))
      else $error("unmapped write changed a register");

   AST_LANE_KEEP: assert property (@(posedge clk) disable iff (reset) // R17
      (wrStrobe && regIdx == 3'h2 && !pstrb[1]) |=> $stable(prioChangeCmpTwowire1_ff[15:8]))
      else $error("upper byte written with its strobe low");

endmodule : ipb_prio_bank

// ===== hdl/ipb_pkg.sv
package ipb_pkg;
   // ****************************************************
   // Register map (byte addresses, one aligned word each)
   // ****************************************************
   localparam logic [11:0] OFF_PRIO_SERIAL1_RX_SPI1_TIMER3 = 12'h000;
   localparam logic [11:0] OFF_PRIO_CONVERTER_SERIAL1_TX   = 12'h004;
   localparam logic [11:0] OFF_PRIO_CHANGE_CMP_TWOWIRE1    = 12'h008;
   localparam logic [11:0] OFF_PRIO_CAPTURE87_EXT1         = 12'h00c;
   localparam logic [11:0] OFF_PRIO_TIMER4_COMPARE43       = 12'h010;
   localparam logic [11:0] OFF_PRIO_SERIAL2_EXT2_TIMER5    = 12'h014;
   localparam int          NUM_REGS                        = 6;

   // ****************************************************
   // Field positions (low bit of each 3-bit field)
   // ****************************************************
   localparam int          FLD_HI  = 12;
   localparam int          FLD_MH  = 8;
   localparam int          FLD_ML  = 4;
   localparam int          FLD_LO  = 0;
   localparam int          PRIO_W  = 3;

   // ****************************************************
   // Priority codes
   // ****************************************************
   localparam logic [2:0]  PRIO_RESET   = 3'h4;
   localparam logic [2:0]  PRIO_OFF     = 3'h0;
   localparam logic [2:0]  PRIO_LOWEST  = 3'h1;
   localparam logic [2:0]  PRIO_HIGHEST = 3'h7;

   // Implemented-bit masks per register
   localparam logic [15:0] MASK_REG0 = 16'h7777;
   localparam logic [15:0] MASK_REG1 = 16'h0077;
   localparam logic [15:0] MASK_REG2 = 16'h7777;
   localparam logic [15:0] MASK_REG3 = 16'h7707;
   localparam logic [15:0] MASK_REG4 = 16'h7770;
   localparam logic [15:0] MASK_REG5 = 16'h7777;
   // Reset images: every implemented field loads level 4
   localparam logic [15:0] RST_REG0  = 16'h4444;
   localparam logic [15:0] RST_REG1  = 16'h0044;
   localparam logic [15:0] RST_REG2  = 16'h4444;
   localparam logic [15:0] RST_REG3  = 16'h4404;
   localparam logic [15:0] RST_REG4  = 16'h4440;
   localparam logic [15:0] RST_REG5  = 16'h4444;
endpackage : ipb_pkg

// ===== testbench/irq_priority_config_bank_tb.sv
`timescale 1ns/10ps
module irq_priority_config_bank_tb;
   import ipb_pkg::*;
   // ****************************************************
   // Bench signals
   // ****************************************************
   logic             clk;
   logic             reset;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [11:0]      paddr;
   logic [31:0]      pwdata;
   logic [3:0]       pstrb;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic [19:0]      srcEnable;
   logic [2:0]       maxLevel;
   wire  [19:0][2:0] fld;
   logic [15:0]      sh [6];
   logic [31:0]      d;
   logic             er;
   int               n_errors = 0;
   int               checked  = 0;
   // Implemented bits worked out from the field layout of each register
   localparam logic [15:0] MSK [6] = '{16'h7777, 16'h0077, 16'h7777, 16'h7707, 16'h7770,
                                       16'h7777};
   // Junk in the unused bits of registers 1, 3 and 4 so that dropped writes are seen
   localparam logic [15:0] PAT [6] = '{16'h1357, 16'hff26, 16'h7531, 16'h62fd, 16'h346f,
                                       16'h2467};
   localparam logic [11:0] OFFS [6] = '{OFF_PRIO_SERIAL1_RX_SPI1_TIMER3,
      OFF_PRIO_CONVERTER_SERIAL1_TX, OFF_PRIO_CHANGE_CMP_TWOWIRE1, OFF_PRIO_CAPTURE87_EXT1,
      OFF_PRIO_TIMER4_COMPARE43, OFF_PRIO_SERIAL2_EXT2_TIMER5};

   ipb_prio_bank u_dut (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr),
      .serial1_rx_prio(fld[19]), .sync_serial1_event_prio(fld[18]),
      .sync_serial1_fault_prio(fld[17]), .timer3_prio(fld[16]),
      .converter_done_prio(fld[15]), .serial1_tx_prio(fld[14]),
      .input_change_prio(fld[13]), .comparator_prio(fld[12]),
      .twowire1_master_prio(fld[11]), .twowire1_slave_prio(fld[10]),
      .capture8_prio(fld[9]), .capture7_prio(fld[8]), .ext_irq1_prio(fld[7]),
      .timer4_prio(fld[6]), .compare4_prio(fld[5]), .compare3_prio(fld[4]),
      .serial2_tx_prio(fld[3]), .serial2_rx_prio(fld[2]), .ext_irq2_prio(fld[1]),
      .timer5_prio(fld[0]), .srcEnable(srcEnable), .maxLevel(maxLevel)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************************
   // Checking and bus tasks
   // ****************************************************
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Holds the request until pready is sampled high, bounded so a hang ends the run
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input int i, input logic [15:0] v, input logic [3:0] s);
      logic [31:0] rd;
      logic        err;
      logic [15:0] m;
      m = MSK[i] & {{8{s[1]}}, {8{s[0]}}};
      apb(1'b1, OFFS[i], {16'hffff, v}, s, rd, err);
      chk(64'(err), 64'h0);
      sh[i] = (sh[i] & ~m) | (v & m);
   endtask : wr

   function automatic logic [59:0] exp_fld();
      return {sh[0][14:12], sh[0][10:8], sh[0][6:4], sh[0][2:0], sh[1][6:4], sh[1][2:0],
              sh[2][14:12], sh[2][10:8], sh[2][6:4], sh[2][2:0], sh[3][14:12], sh[3][10:8],
              sh[3][2:0], sh[4][14:12], sh[4][10:8], sh[4][6:4], sh[5][14:12], sh[5][10:8],
              sh[5][6:4], sh[5][2:0]};
   endfunction : exp_fld

   task automatic check_all();
      logic [59:0] e;
      logic [19:0] en;
      logic [2:0]  mx;
      logic [31:0] rd;
      logic        err;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, OFFS[i], 32'h0, 4'h0, rd, err);
         chk(64'(rd), 64'(sh[i]));
         chk(64'(err), 64'h0);
      end
      // Field outputs are looked at once the last edge's updates have landed
      @(negedge clk);
      e = exp_fld();
      en = '0;
      mx = '0;
      for (int i = 0; i < 20; i++) begin
         en[i] = |e[i*3+:3];
         if (e[i*3+:3] > mx) begin
            mx = e[i*3+:3];
         end
      end
      chk(64'(fld), 64'(e));
      chk(64'(srcEnable), 64'(en));
      chk(64'(maxLevel), 64'(mx));
   endtask : check_all

   task automatic load_reset_images();
      for (int i = 0; i < 6; i++) begin
         sh[i] = 16'h4444 & MSK[i];
      end
   endtask : load_reset_images

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      load_reset_images();
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      check_all();
      for (int i = 0; i < 6; i++) wr(i, 16'hffff, 4'h3);
      check_all();
      for (int i = 0; i < 6; i++) begin
         wr(i, PAT[i], 4'h3);
         check_all();
      end
      for (int i = 0; i < 6; i++) wr(i, 16'h0000, 4'h3);
      check_all();
      wr(0, 16'h0001, 4'h3);
      check_all();
      wr(5, 16'h0006, 4'h3);
      check_all();
      // Byte lanes with their strobe low keep their old contents
      wr(2, 16'h7777, 4'h1);
      wr(3, 16'h7777, 4'h2);
      check_all();
      apb(1'b1, 12'h018, 32'hffffffff, 4'hf, d, er);
      chk(64'(er), 64'h1);
      apb(1'b0, 12'h018, 32'h0, 4'h0, d, er);
      chk(64'(d), 64'h0);
      chk(64'(er), 64'h1);
      check_all();
      // Second reset in mid-run after fields were changed
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      load_reset_images();
      check_all();
      tally_and_finish();
   end
endmodule : irq_priority_config_bank_tb
